// ==== hdl/hzr_unit.sv ====
module hzr_unit (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [3:0]        regAddr,
	input  wire logic [15:0]       regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [15:0]            regRdata,
	input  wire logic [3:0]        hizRequestIn_n,
	input  wire logic              hwStandby,
	input  hzr_pkg::hzr_pwm_s      pwmIn,
	input  wire logic [6:0]        pinOtherUse,
	output hzr_pkg::hzr_pwm_s      pwmPins,
	output logic                   irqRequest,
	output logic                   hizActive
);

	logic [3:0]               flags;
	logic [3:0]               armed;
	logic                     irqEnable;
	logic [7:0]               modes;
	logic [3:0]               pinAssign;
	logic [6:0]               prescale;
	logic [2:0]               ticks;
	logic [3:0]               detect;
	logic                     icsWrite;
	logic                     icsRead;
	logic                     pinWrite;
	logic                     pinRead;
	logic [3:0]               clearMask;
	logic [3:0]               next_flags;
	logic [15:0]              next_rdata;
	logic [6:0]               forceMask;

	// true when every bit of mask is set in the prescaler
	function automatic logic tickAt(
		input logic [6:0] count,
		input logic [6:0] mask
	);
		tickAt = (count & mask) == mask;
	endfunction

	// address decode, shared by reads and writes
	function automatic logic hit(
		input logic [3:0] addr,
		input logic [3:0] target
	);
		hit = addr == target;
	endfunction

	assign icsWrite = regWrite && hit(regAddr, hzr_pkg::ADDR_ICS);
	assign icsRead  = regRead && hit(regAddr, hzr_pkg::ADDR_ICS);
	assign pinWrite = regWrite && hit(regAddr, hzr_pkg::ADDR_PIN);
	assign pinRead  = regRead && hit(regAddr, hzr_pkg::ADDR_PIN);

	// one free running prescaler serves all three sampling rates
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			prescale <= 7'h00;
		else
			prescale <= prescale + 7'h01;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ticks <= 3'h0;
		else
		begin
			ticks[0] <= tickAt(prescale, hzr_pkg::DIV8_MASK);
			ticks[1] <= tickAt(prescale, hzr_pkg::DIV16_MASK);
			ticks[2] <= tickAt(prescale, hzr_pkg::DIV128_MASK);
		end
	end

	// one detector per request input; each synchronises its own pin
	for (genvar i = 0; i < hzr_pkg::INPUTS; i++)
	begin : g_input
		hzr_detector u_detector (
			.clock   (clock),
			.rst_n   (rst_n),
			.pinIn_n (hizRequestIn_n[i]),
			.enable  (pinAssign[i]),
			.mode    (hzr_pkg::hzr_mode_e'(modes[2*i +: 2])),
			.ticks   (ticks),
			.detect  (detect[i])
		);
	end

	// a zero write clears only flags that were read as one
	always_comb
	begin
		clearMask = 4'h0;
		if (icsWrite)
			clearMask = armed &
				~regWdata[hzr_pkg::FLAG_MSB:hzr_pkg::FLAG_LSB];
	end

	// a new detection wins over a clear in the same cycle
	assign next_flags = (flags & ~clearMask) | detect;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			flags <= hzr_pkg::FLAG_RST;
		else if (hwStandby)
			flags <= hzr_pkg::FLAG_RST;
		else
			flags <= next_flags;
	end

	// arm on a read that returned one, disarm on any control write
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			armed <= 4'h0;
		else if (hwStandby || icsWrite)
			armed <= 4'h0;
		else if (icsRead)
			armed <= armed | flags;
	end

	// mode and enable fields; software standby does not touch them
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqEnable <= 1'b0;
			modes     <= hzr_pkg::MODE_RST;
		end
		else if (hwStandby)
		begin
			irqEnable <= 1'b0;
			modes     <= hzr_pkg::MODE_RST;
		end
		else if (icsWrite)
		begin
			irqEnable <= regWdata[hzr_pkg::IRQ_EN_BIT];
			modes     <= regWdata[hzr_pkg::MODE_MSB:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pinAssign <= hzr_pkg::ASSIGN_RST;
		else if (pinWrite)
			pinAssign <=
				regWdata[hzr_pkg::ASSIGN_MSB:hzr_pkg::ASSIGN_LSB];
	end

	// read data stand for one cycle only; unmapped reads give zero
	always_comb
	begin
		next_rdata = 16'h0000;
		if (icsRead)
		begin
			next_rdata[hzr_pkg::FLAG_MSB:hzr_pkg::FLAG_LSB] = flags;
			next_rdata[hzr_pkg::IRQ_EN_BIT]                = irqEnable;
			next_rdata[hzr_pkg::MODE_MSB:0]                = modes;
		end
		else if (pinRead)
			next_rdata[hzr_pkg::ASSIGN_MSB:hzr_pkg::ASSIGN_LSB] = pinAssign;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			regRdata <= 16'h0000;
		else
			regRdata <= next_rdata;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irqRequest <= 1'b0;
		else
			irqRequest <= irqEnable && (flags != 4'h0);
	end

	// held while any flag stands, so only reset, hardware standby or a full clear ends it
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			hizActive <= 1'b0;
		else
			hizActive <= flags != 4'h0;
	end

	// pins in port or other timer use are left alone
	assign forceMask = {hzr_pkg::PWM_PINS{hizActive}} & ~pinOtherUse;

	// costs one cycle of pwm latency so every pin leaves a flip-flop
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwmPins.level  <= 7'h00;
			pwmPins.enable <= 7'h00;
		end
		else
		begin
			pwmPins.level  <= pwmIn.level;
			pwmPins.enable <= pwmIn.enable & ~forceMask;
		end
	end

	a_flag_set: assert property (
		@(posedge clock) disable iff (!rst_n)
		(detect != 4'h0 && !hwStandby)
		|=> ((flags & $past(detect)) == $past(detect)))
		else $error("detected input did not set its flag");

	a_clear_needs_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		(icsWrite && !hwStandby)
		|=> ((flags & $past(flags) & ~$past(armed))
			== ($past(flags) & ~$past(armed))))
		else $error("flag cleared without a prior read of one");

	// the clearing write may follow the read at once; this check leaves one idle cycle between them
	a_clear_after_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		(icsRead && flags[0] && !hwStandby)
		##1 (!icsWrite && !hwStandby)
		##1 (icsWrite && !regWdata[hzr_pkg::FLAG_LSB] && !detect[0]
			&& !hwStandby)
		|=> !flags[0])
		else $error("read one then write zero did not clear");

	a_write_no_set: assert property (
		@(posedge clock) disable iff (!rst_n)
		(icsWrite && detect == 4'h0)
		|=> ((flags & ~$past(flags)) == 4'h0))
		else $error("write of one set a flag");

	a_reserved_zero: assert property (
		@(posedge clock) disable iff (!rst_n)
		icsRead |=> (regRdata[hzr_pkg::RSV_MSB:hzr_pkg::RSV_LSB] == 3'h0))
		else $error("reserved bits read nonzero");

	a_irq_gate: assert property (
		@(posedge clock) disable iff (!rst_n)
		##1 (irqRequest == ($past(irqEnable) && $past(flags) != 4'h0)))
		else $error("interrupt request disagrees with flags and enable");

	a_tick_spacing: assert property (
		@(posedge clock) disable iff (!rst_n)
		ticks[0] |=> (!ticks[0])[*7] ##1 ticks[0])
		else $error("clock/8 tick spacing wrong");

	a_tick_nesting: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ticks[2] |-> ticks[1]) and (ticks[1] |-> ticks[0]))
		else $error("sampling ticks not nested");

	a_mode_write: assert property (
		@(posedge clock) disable iff (!rst_n)
		(icsWrite && !hwStandby) |=> (modes == $past(regWdata[7:0])))
		else $error("mode fields did not take the written value");

	a_detect_latency: assert property (
		@(posedge clock) disable iff (!rst_n)
		(detect != 4'h0 && !hwStandby) |=> ##1 hizActive)
		else $error("high impedance not entered two edges after detect");

	a_pins_forced: assert property (
		@(posedge clock) disable iff (!rst_n)
		hizActive |=> ((pwmPins.enable & ~$past(pinOtherUse)) == 7'h00))
		else $error("forced pwm pin still driven");

	// the reset edge still loads zero into the pins, so it is skipped
	a_other_use_kept: assert property (
		@(posedge clock) disable iff (!rst_n)
		rst_n |=> ((pwmPins.enable & $past(pinOtherUse))
			== ($past(pwmIn.enable) & $past(pinOtherUse))))
		else $error("pin in other use was disturbed");

	a_release: assert property (
		@(posedge clock) disable iff (!rst_n)
		(hizActive && flags != 4'h0) |=> hizActive)
		else $error("high impedance released while a flag stands");

	a_standby_init: assert property (
		@(posedge clock) disable iff (!rst_n)
		hwStandby |=> (flags == 4'h0 && modes == 8'h00 && !irqEnable))
		else $error("hardware standby did not initialise status");

	a_flag_readback: assert property (
		@(posedge clock) disable iff (!rst_n)
		icsRead |=> (regRdata[hzr_pkg::FLAG_MSB:hzr_pkg::FLAG_LSB]
			== $past(flags)))
		else $error("flag read back differs from flag state");

	a_flag_sticky: assert property (
		@(posedge clock) disable iff (!rst_n)
		(!icsWrite && !hwStandby)
		|=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag dropped without a clearing write");

	a_irq_off: assert property (
		@(posedge clock) disable iff (!rst_n)
		!irqEnable |=> !irqRequest)
		else $error("interrupt raised while disabled");

	a_hiz_clear: assert property (
		@(posedge clock) disable iff (!rst_n)
		(flags == 4'h0) |=> !hizActive)
		else $error("high impedance held with all flags clear");

	a_pins_free: assert property (
		@(posedge clock) disable iff (!rst_n)
		(rst_n && !hizActive)
		|=> (pwmPins.enable == $past(pwmIn.enable)))
		else $error("pwm pin forced without a request");

	a_level_copy: assert property (
		@(posedge clock) disable iff (!rst_n)
		rst_n |=> (pwmPins.level == $past(pwmIn.level)))
		else $error("pwm pin level not passed through");

	a_tick_div16: assert property (
		@(posedge clock) disable iff (!rst_n)
		ticks[1] |-> (prescale[3:0] == 4'h0))
		else $error("clock/16 tick out of phase");

	a_tick_div128: assert property (
		@(posedge clock) disable iff (!rst_n)
		ticks[2] |-> (prescale == 7'h00))
		else $error("clock/128 tick out of phase");

	a_idle_rdata: assert property (
		@(posedge clock) disable iff (!rst_n)
		!(icsRead || pinRead) |=> (regRdata == 16'h0000))
		else $error("read data not zero outside a read");

	a_pin_readback: assert property (
		@(posedge clock) disable iff (!rst_n)
		pinRead |=> (regRdata == {8'h00, $past(pinAssign), 4'h0}))
		else $error("pin assign read back wrong");

endmodule

// ==== hdl/hzr_pkg.sv ====
package hzr_pkg;

	// register byte addresses on the plain register port
	localparam logic [3:0]  ADDR_ICS       = 4'h0;
	localparam logic [3:0]  ADDR_PIN       = 4'h2;

	// control/status field positions
	localparam int          FLAG_LSB       = 12;
	localparam int          FLAG_MSB       = 15;
	localparam int          RSV_LSB        = 9;
	localparam int          RSV_MSB        = 11;
	localparam int          IRQ_EN_BIT     = 8;
	localparam int          MODE_MSB       = 7;
	localparam int          MODE_W         = 2;

	// pin assign field position
	localparam int          ASSIGN_LSB     = 4;
	localparam int          ASSIGN_MSB     = 7;

	// reset values
	localparam logic [3:0]  FLAG_RST       = 4'h0;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [3:0]  ASSIGN_RST     = 4'h0;

	// sampling clock masks on the free running prescaler
	localparam int          PRESCALE_W     = 7;
	localparam logic [6:0]  DIV8_MASK      = 7'h07;
	localparam logic [6:0]  DIV16_MASK     = 7'h0f;
	localparam logic [6:0]  DIV128_MASK    = 7'h7f;

	// last low count before detect; level modes need 16 consecutive low samples
	localparam logic [4:0]  SAMPLE_LAST    = 5'h0f;

	localparam int          INPUTS         = 4;
	localparam int          PWM_PINS       = 7;

	typedef enum logic [1:0] {
		MODE_EDGE   = 2'h0,
		MODE_DIV8   = 2'h1,
		MODE_DIV16  = 2'h2,
		MODE_DIV128 = 2'h3
	} hzr_mode_e;

	// one pwm pin group: level and output enable
	typedef struct packed {
		logic [6:0] level;
		logic [6:0] enable;
	} hzr_pwm_s;

endpackage

// ==== hdl/hzr_detector.sv ====
module hzr_detector (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              pinIn_n,
	input  wire logic              enable,
	input  hzr_pkg::hzr_mode_e     mode,
	input  wire logic [2:0]        ticks,
	output logic                   detect
);

	logic       sync1;
	logic       sync2;
	logic       sync3;
	logic       level;
	logic       levelPrev;
	logic [4:0] lowCount;
	logic       tickSel;

	// the first stage feeds only the second
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end
		else
		begin
			sync1 <= pinIn_n;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a change counts only once two stages agree
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			level     <= 1'b1;
			levelPrev <= 1'b1;
		end
		else
		begin
			if (sync2 == sync3)
				level <= sync3;
			levelPrev <= level;
		end
	end

	always_comb
	begin
		unique case (mode)
			hzr_pkg::MODE_DIV8:   tickSel = ticks[0];
			hzr_pkg::MODE_DIV16:  tickSel = ticks[1];
			hzr_pkg::MODE_DIV128: tickSel = ticks[2];
			hzr_pkg::MODE_EDGE:   tickSel = 1'b0;
		endcase
	end

	// both paths register detect one edge after their sampling event
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lowCount <= 5'h00;
			detect   <= 1'b0;
		end
		else if (!enable)
		begin
			lowCount <= 5'h00;
			detect   <= 1'b0;
		end
		else if (mode == hzr_pkg::MODE_EDGE)
		begin
			lowCount <= 5'h00;
			detect   <= levelPrev & ~level;
		end
		else if (tickSel)
		begin
			if (level)
			begin
				lowCount <= 5'h00;
				detect   <= 1'b0;
			end
			else if (lowCount == hzr_pkg::SAMPLE_LAST)
			begin
				lowCount <= 5'h00;
				detect   <= 1'b1;
			end
			else
			begin
				lowCount <= lowCount + 5'h01;
				detect   <= 1'b0;
			end
		end
		else
			detect <= 1'b0;
	end

	a_edge_accept: assert property (
		@(posedge clock) disable iff (!rst_n)
		(enable && mode == hzr_pkg::MODE_EDGE && levelPrev && !level)
		|=> detect)
		else $error("falling edge not accepted");

	a_high_restart: assert property (
		@(posedge clock) disable iff (!rst_n)
		(enable && mode != hzr_pkg::MODE_EDGE && tickSel && level)
		|=> (lowCount == 5'h00 && !detect))
		else $error("high sample did not restart count");

	a_disabled_quiet: assert property (
		@(posedge clock) disable iff (!rst_n)
		!enable |=> !detect)
		else $error("unassigned input raised a request");

endmodule

// ==== sim/hzr_fault_source.sv ====
module hzr_fault_source (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [3:0] faultOn,
	output logic      [3:0] hizRequestIn_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// open-drain fault lines with pull-ups: a released line reads high
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			hizRequestIn_n <= 4'hf;
		else
			hizRequestIn_n <= ~faultOn;
	end
endmodule

// ==== sim/tb_top.sv ====
`define CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("wrong value at %0t: got %h expected %h", \
				$time, got, exp); \
		end \
	end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clock;
	logic               rst_n;
	logic [3:0]         regAddr;
	logic [15:0]        regWdata;
	logic               regWrite;
	logic               regRead;
	logic [15:0]        regRdata;
	logic [3:0]         hizRequestIn_n;
	logic               hwStandby;
	hzr_pkg::hzr_pwm_s  pwmIn;
	logic [6:0]         pinOtherUse;
	hzr_pkg::hzr_pwm_s  pwmPins;
	logic               irqRequest;
	logic               hizActive;
	logic [3:0]         faultOn;
	int                 n_mismatch;
	int                 checks;
	int                 divs [3] = '{8, 16, 128};
	logic [15:0]        rdv;

	hzr_unit dut (
		.clock          (clock),
		.rst_n          (rst_n),
		.regAddr        (regAddr),
		.regWdata       (regWdata),
		.regWrite       (regWrite),
		.regRead        (regRead),
		.regRdata       (regRdata),
		.hizRequestIn_n (hizRequestIn_n),
		.hwStandby      (hwStandby),
		.pwmIn          (pwmIn),
		.pinOtherUse    (pinOtherUse),
		.pwmPins        (pwmPins),
		.irqRequest     (irqRequest),
		.hizActive      (hizActive)
	);

	hzr_fault_source fault (
		.clock          (clock),
		.rst_n          (rst_n),
		.faultOn        (faultOn),
		.hizRequestIn_n (hizRequestIn_n)
	);

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask

	task automatic waitn(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic pulse(input logic [3:0] m, input int n);
		@(posedge clock);
		faultOn <= m;
		repeat (n) @(posedge clock);
		faultOn <= 4'h0;
		waitn(12);
	endtask

	task automatic close_out;
		$display("mismatches %0d, checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// longest level test needs about 4400 cycles
	initial
	begin
		#200000;
		n_mismatch++;
		close_out();
	end

	initial
	begin
		rst_n       = 1'b0;
		regAddr     = 4'h0;
		regWdata    = 16'h0000;
		regWrite    = 1'b0;
		regRead     = 1'b0;
		hwStandby   = 1'b0;
		pwmIn       = {7'h55, 7'h7f};
		pinOtherUse = 7'h41;
		faultOn     = 4'h0;
		n_mismatch  = 0;
		checks      = 0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h0000)
		rd(hzr_pkg::ADDR_PIN, rdv);
		`CHK(rdv, 16'h0000)
		`CHK(hizActive, 1'b0)
		// register access, unmapped places; reserved bits written 0
		wr(hzr_pkg::ADDR_ICS, 16'hf1ff);
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h01ff)
		wr(hzr_pkg::ADDR_PIN, 16'hffff);
		rd(hzr_pkg::ADDR_PIN, rdv);
		`CHK(rdv, 16'h00f0)
		wr(4'h4, 16'hffff);
		rd(4'h4, rdv);
		`CHK(rdv, 16'h0000)
		@(posedge clock);
		hwStandby <= 1'b1;
		@(posedge clock);
		hwStandby <= 1'b0;
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h0000)
		rd(hzr_pkg::ADDR_PIN, rdv);
		`CHK(rdv, 16'h00f0)
		// edge mode; input one is not assigned and must be ignored
		wr(hzr_pkg::ADDR_PIN, 16'h0010);
		wr(hzr_pkg::ADDR_ICS, 16'h0100);
		pulse(4'h2, 8);
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h0100)
		`CHK(hizActive, 1'b0)
		pulse(4'h1, 8);
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h1100)
		waitn(4);
		`CHK(hizActive, 1'b1)
		`CHK(irqRequest, 1'b1)
		`CHK(pwmPins.enable, 7'h41)
		`CHK(pwmPins.level, 7'h55)
		// a write disarms, so the zero write after it must not clear
		wr(hzr_pkg::ADDR_ICS, 16'h1100);
		wr(hzr_pkg::ADDR_ICS, 16'h0100);
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h1100)
		wr(hzr_pkg::ADDR_ICS, 16'h0000);
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h0000)
		waitn(4);
		`CHK(hizActive, 1'b0)
		`CHK(irqRequest, 1'b0)
		`CHK(pwmPins.enable, 7'h7f)
		pulse(4'h1, 8);
		waitn(4);
		`CHK(irqRequest, 1'b0)
		`CHK(hizActive, 1'b1)
		rd(hzr_pkg::ADDR_ICS, rdv);
		`CHK(rdv, 16'h1000)
		wr(hzr_pkg::ADDR_ICS, 16'h0000);
		// level modes: 15 lows, a high, then a long low
		wr(hzr_pkg::ADDR_PIN, 16'h00f0);
		wr(hzr_pkg::ADDR_ICS, 16'h00e4);
		for (int i = 1; i < 4; i++)
		begin
			@(posedge clock);
			faultOn <= 4'h1 << i;
			waitn(15 * divs[i-1] - 4);
			faultOn <= 4'h0;
			waitn(2 * divs[i-1]);
			faultOn <= 4'h1 << i;
			waitn(15 * divs[i-1] - 4);
			rd(hzr_pkg::ADDR_ICS, rdv);
			`CHK(rdv, 16'h00e4)
			waitn(2 * divs[i-1] + 8);
			rd(hzr_pkg::ADDR_ICS, rdv);
			`CHK(rdv, 16'h00e4 | (16'h1000 << i))
			`CHK(hizActive, 1'b1)
			`CHK(pwmPins.enable, 7'h41)
			faultOn <= 4'h0;
			waitn(4);
			rd(hzr_pkg::ADDR_ICS, rdv);
			wr(hzr_pkg::ADDR_ICS, 16'h00e4);
			waitn(4);
			`CHK(hizActive, 1'b0)
			`CHK(pwmPins.enable, 7'h7f)
		end
		close_out();
	end
endmodule
